// ===== core/vpc_ctrl.v
// Purpose: valve position indication, monitoring, valve state and pulse clean
// Assumes: band inputs from the position sensor, Avalon-MM register access
// Notes:   long times are parameters so a simulation can shorten them
//
// What this block does
// - the ring shows green, white, blue or yellow per band, off between, flashing in factory mode, red mixed in on a fault.
// - position feedback is given as de-energised and energised, never as open or closed.
// - rule-based setup enables cleaning and the monitors and uses valve state, retrofit setup disables them and uses status error.
// - valve state stays high in rule-based setup while the device and valve idle with no fault.
// - pulse cleaning is not ready after reset: ctrl must first select the fieldbus variant and one solenoid valve.
// - a clean energises the solenoid until the energised band is seen, then releases it.
// - no new clean request is taken until 2 s after the last one completes.
// - a completed clean gives a 2 s feedback pulse and indicator pulse.
// - cleaning is off on the discrete variant and needs one solenoid valve on fieldbus variants.
// - a missing target, a position not reached or an unexpected movement drives valve state low.
`timescale 1ns/1ps
`default_nettype none
`include "vpc_defines.vh"
module vpc_ctrl #(
  parameter TRIG_CYCLES  = `VPC_TRIG_MIN_MS * 1000 * `VPC_CLK_MHZ,
  parameter HOLD_CYCLES  = `VPC_HOLD_MS * 1000 * `VPC_CLK_MHZ,
  parameter FLASH_CYCLES = `VPC_FLASH_MS * 1000 * `VPC_CLK_MHZ,
  parameter POS_CYCLES   = `VPC_POS_TIMEOUT_MS * 1000 * `VPC_CLK_MHZ
) (
  input  wire        clock,
  input  wire        reset_n,
  input  wire [7:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  input  wire [3:0]  byteenable,
  output reg  [31:0] readdata,
  output reg         waitrequest,
  input  wire        clean_trigger,
  input  wire        energise_cmd,
  input  wire        target_present,
  input  wire        band_deenergised,
  input  wire        band_energised,
  input  wire        band_upper_lift,
  input  wire        band_lower_push,
  output reg         solenoid_output,
  output reg         valve_state,
  output reg         status_error,
  output reg         fb_energised,
  output reg         fb_deenergised,
  output reg         clean_done,
  output reg  [4:0]  features_enabled,
  output reg         led_green,
  output reg         led_white,
  output reg         led_blue,
  output reg         led_yellow,
  output reg         led_red,
  output reg         irq
);

  // ----------------------------------------
  // state codes
  // ----------------------------------------
  localparam [1:0] ST_IDLE   = 2'd0;
  localparam [1:0] ST_DRIVE  = 2'd1;
  localparam [1:0] ST_RETURN = 2'd2;
  localparam [1:0] ST_HOLD   = 2'd3;
  localparam TW = `VPC_TIMER_W;
  function [TW-1:0] to_tw;
    input integer n;
    begin
      to_tw = n[TW-1:0];
    end
  endfunction
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [6:0] pins_sync;
  vpc_sync #(
    .WIDTH (7)
  ) u_sync (
    .clock    (clock),
    .reset_n  (reset_n),
    .async_in ({clean_trigger, energise_cmd, target_present, band_deenergised,
                band_energised, band_upper_lift, band_lower_push}),
    .sync_out (pins_sync)
  );
  wire trig_s    = pins_sync[6];
  wire cmd_s     = pins_sync[5];
  wire present_s = pins_sync[4];
  wire b_de      = pins_sync[3];
  wire b_en      = pins_sync[2];
  wire b_up      = pins_sync[1];
  wire b_lo      = pins_sync[0];

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [`VPC_CTRL_W-1:0] ctrl;
  reg [`VPC_IRQ_W-1:0]  irq_stat;
  reg [`VPC_IRQ_W-1:0]  irq_mask;
  wire flex      = ctrl[`VPC_CTRL_FLEX];
  wire fieldbus  = ctrl[`VPC_CTRL_FIELDBUS];
  wire [1:0] svn = ctrl[`VPC_CTRL_SV_HI:`VPC_CTRL_SV_LO];
  wire factory   = ctrl[`VPC_CTRL_FACTORY];
  // retrofit setup turns every monitoring feature off
  wire monitors_on = !flex;
  // discrete variant has no clean, fieldbus needs exactly one valve
  wire clean_ok = monitors_on && fieldbus && (svn == 2'd1);

  // ----------------------------------------
  // position monitor
  // ----------------------------------------
  reg          reached;
  reg          last_sol;
  reg [TW-1:0] pos_timer;
  reg          fault;
  reg          fault_q;
  reg [1:0]    warm;
  // faults wait until the synchronisers hold real pin levels, else reset raises a false fault
  wire         pins_ok = warm[1];
  wire at_target     = solenoid_output ? b_en : b_de;
  wire f_missing     = !present_s;
  wire f_not_reached = !reached && (pos_timer >= to_tw(POS_CYCLES));
  wire f_unexpected  = reached && !at_target && (last_sol == solenoid_output);
  wire next_fault    = pins_ok && monitors_on && (f_missing || f_not_reached || f_unexpected);
  always @(posedge clock) begin
    if (!reset_n) begin
      warm      <= 2'b00;
      reached   <= 1'b0;
      last_sol  <= 1'b0;
      pos_timer <= {TW{1'b0}};
      fault     <= 1'b0;
      fault_q   <= 1'b0;
    end else begin
      if (!pins_ok) begin
        warm <= warm + 2'b01;
      end
      last_sol <= solenoid_output;
      fault    <= next_fault;
      fault_q  <= fault;
      if (last_sol != solenoid_output) begin
        reached   <= 1'b0;
        pos_timer <= {TW{1'b0}};
      end else if (at_target) begin
        reached   <= 1'b1;
        pos_timer <= {TW{1'b0}};
      end else if (!reached && pos_timer < to_tw(POS_CYCLES)) begin
        pos_timer <= pos_timer + 1'b1;
      end
    end
  end

  // ----------------------------------------
  // trigger qualification
  // ----------------------------------------
  reg [TW-1:0] trig_cnt;
  reg          trig_armed;
  wire         trig_long = trig_s && (trig_cnt >= to_tw(TRIG_CYCLES) - 1'b1);
  always @(posedge clock) begin
    if (!reset_n) begin
      trig_cnt <= {TW{1'b0}};
    end else if (!trig_s) begin
      trig_cnt <= {TW{1'b0}};
    end else if (trig_cnt < to_tw(TRIG_CYCLES)) begin
      trig_cnt <= trig_cnt + 1'b1;
    end
  end

  // ----------------------------------------
  // pulse clean sequence
  // ----------------------------------------
  reg [1:0]    state;
  reg [1:0]    next_state;
  reg [TW-1:0] hold_cnt;
  reg          next_sol;
  reg          ev_done;
  reg          ev_reject;
  // a request is only taken while the valve rests de-energised
  wire can_start = clean_ok && !fault && !cmd_s && b_de;
  always @* begin
    next_state = state;
    next_sol   = cmd_s;
    ev_done    = 1'b0;
    ev_reject  = 1'b0;
    case (state)
      ST_IDLE: begin
        if (trig_long && trig_armed) begin
          if (can_start) begin
            next_state = ST_DRIVE;
            next_sol   = 1'b1;
          end else begin
            ev_reject = 1'b1;
          end
        end
      end
      ST_DRIVE: begin
        next_sol = 1'b1;
        if (b_en) begin
          next_state = ST_RETURN;
          next_sol   = 1'b0;
        end else if (fault) begin
          next_state = ST_IDLE;
          next_sol   = 1'b0;
        end
      end
      ST_RETURN: begin
        next_sol = 1'b0;
        if (b_de) begin
          next_state = ST_HOLD;
          ev_done    = 1'b1;
        end else if (fault) begin
          next_state = ST_IDLE;
        end
      end
      ST_HOLD: begin
        if (hold_cnt >= to_tw(HOLD_CYCLES) - 1'b1) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
        next_sol   = 1'b0;
      end
    endcase
  end
  always @(posedge clock) begin
    if (!reset_n) begin
      state           <= ST_IDLE;
      hold_cnt        <= {TW{1'b0}};
      solenoid_output <= 1'b0;
      clean_done      <= 1'b0;
      trig_armed      <= 1'b0;
    end else begin
      state           <= next_state;
      solenoid_output <= next_sol;
      if (state == ST_HOLD) begin
        hold_cnt <= hold_cnt + 1'b1;
      end else begin
        hold_cnt <= {TW{1'b0}};
      end
      // feedback pulse spans the whole hold-off
      clean_done <= (next_state == ST_HOLD);
      // one accepted request per trigger assertion
      if (!trig_s) begin
        trig_armed <= 1'b1;
      end else if (state == ST_IDLE && trig_long) begin
        trig_armed <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // status outputs
  // ----------------------------------------
  always @(posedge clock) begin
    if (!reset_n) begin
      valve_state      <= 1'b0;
      status_error     <= 1'b0;
      fb_energised     <= 1'b0;
      fb_deenergised   <= 1'b0;
      features_enabled <= 5'h00;
    end else begin
      valve_state      <= monitors_on && !next_fault;
      status_error     <= pins_ok && flex && (f_missing || f_not_reached || f_unexpected);
      fb_energised     <= b_en;
      fb_deenergised   <= b_de;
      features_enabled <= {5{monitors_on}};
    end
  end
  // ----------------------------------------
  // ring indicator
  // ----------------------------------------
  reg [TW-1:0] flash_cnt;
  reg          flash;
  reg [3:0]    colour;
  reg [3:0]    next_colour;
  reg          next_red;
  // colour bits: green, white, blue, yellow
  always @* begin
    colour = {b_de, b_en && !b_de, b_up, b_lo};
    next_colour = 4'h0;
    next_red    = 1'b0;
    if (clean_done) begin
      next_colour = 4'h4;
    end else if (fault) begin
      if (colour == 4'h0) begin
        next_red = flash;
      end else begin
        next_colour = flash ? colour : 4'h0;
        next_red    = !flash;
      end
    end else if (factory) begin
      next_colour = flash ? colour : 4'h0;
    end else begin
      next_colour = colour;
    end
  end
  always @(posedge clock) begin
    if (!reset_n) begin
      flash_cnt  <= {TW{1'b0}};
      flash      <= 1'b0;
      led_green  <= 1'b0;
      led_white  <= 1'b0;
      led_blue   <= 1'b0;
      led_yellow <= 1'b0;
      led_red    <= 1'b0;
    end else begin
      if (flash_cnt >= to_tw(FLASH_CYCLES) - 1'b1) begin
        flash_cnt <= {TW{1'b0}};
        flash     <= !flash;
      end else begin
        flash_cnt <= flash_cnt + 1'b1;
      end
      led_green  <= next_colour[3];
      led_white  <= next_colour[2];
      led_blue   <= next_colour[1];
      led_yellow <= next_colour[0];
      led_red    <= next_red;
    end
  end
  // ----------------------------------------
  // register bus slave
  // ----------------------------------------
  // one wait state: answer data is registered, so the bus sees no comb path
  wire req    = (read || write) && waitrequest;
  wire wr_acc = write && !waitrequest;
  wire [`VPC_IRQ_W-1:0] events = {ev_reject, fault && !fault_q, ev_done};
  wire [`VPC_IRQ_W-1:0] w1c = (wr_acc && address == `VPC_REG_IRQ_STAT && byteenable[0]) ?
                              writedata[`VPC_IRQ_W-1:0] : {`VPC_IRQ_W{1'b0}};
  reg [31:0] next_rdata;
  always @* begin
    case (address)
      `VPC_REG_CTRL:     next_rdata = {27'h0, ctrl};
      `VPC_REG_STATUS:   next_rdata = {18'h0, monitors_on, clean_ok, fault, f_unexpected,
                                       f_not_reached, f_missing, state, 2'h0, b_lo, b_up,
                                       b_en, b_de};
      `VPC_REG_IRQ_STAT: next_rdata = {29'h0, irq_stat};
      `VPC_REG_IRQ_MASK: next_rdata = {29'h0, irq_mask};
      default:           next_rdata = 32'h0;
    endcase
  end
  always @(posedge clock) begin
    if (!reset_n) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0;
      ctrl        <= `VPC_CTRL_RESET;
      irq_stat    <= {`VPC_IRQ_W{1'b0}};
      irq_mask    <= `VPC_IRQ_MASK_RESET;
      irq         <= 1'b0;
    end else begin
      waitrequest <= !req;
      if (req && read) begin
        readdata <= next_rdata;
      end
      if (wr_acc && byteenable[0]) begin
        if (address == `VPC_REG_CTRL) begin
          ctrl <= writedata[`VPC_CTRL_W-1:0];
        end
        if (address == `VPC_REG_IRQ_MASK) begin
          irq_mask <= writedata[`VPC_IRQ_W-1:0];
        end
      end
      // a new event wins over a clear in the same cycle
      irq_stat <= (irq_stat & ~w1c) | events;
      irq      <= |(((irq_stat & ~w1c) | events) & irq_mask);
    end
  end

endmodule
`default_nettype wire

// ===== core/vpc_defines.vh
// Purpose: shared constants of the valve position and pulse clean controller
// Assumes: 100 MHz system clock, byte-addressed register bus
// Notes:   timing figures kept in their own units, cycles derived where used
`ifndef VPC_DEFINES_VH
`define VPC_DEFINES_VH

// ----------------------------------------
// clock and timing
// ----------------------------------------
`define VPC_CLK_MHZ        100
`define VPC_TRIG_MIN_MS    500
`define VPC_HOLD_MS        2000
`define VPC_FLASH_MS       250
`define VPC_POS_TIMEOUT_MS 3000
`define VPC_TIMER_W        30

// ----------------------------------------
// register offsets
// ----------------------------------------
`define VPC_REG_CTRL       8'h00
`define VPC_REG_STATUS     8'h04
`define VPC_REG_IRQ_STAT   8'h08
`define VPC_REG_IRQ_MASK   8'h0c

// ----------------------------------------
// control fields
// ----------------------------------------
`define VPC_CTRL_FLEX      0
`define VPC_CTRL_FIELDBUS  1
`define VPC_CTRL_SV_LO     2
`define VPC_CTRL_SV_HI     3
`define VPC_CTRL_FACTORY   4
`define VPC_CTRL_W         5
`define VPC_CTRL_RESET     5'h10

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define VPC_IRQ_DONE       0
`define VPC_IRQ_FAULT      1
`define VPC_IRQ_REJECT     2
`define VPC_IRQ_W          3
`define VPC_IRQ_MASK_RESET 3'h0

`endif

// ===== core/vpc_sync.v
// Purpose: two-stage synchroniser for pin inputs
// Assumes: inputs are asynchronous levels
// Notes:   the first stage feeds the second stage only
`timescale 1ns/1ps
`default_nettype none

module vpc_sync #(
  parameter WIDTH = 1
) (
  input  wire             clock,
  input  wire             reset_n,
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta;

  always @(posedge clock) begin
    if (!reset_n) begin
      meta     <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ===== test/vpc_checker.sv
// Purpose: port assertions for the pulse clean controller
// Assumes: HOLD_CYCLES equals the instance value
// Notes:   energise_cmd kept low wherever the solenoid is judged
`timescale 1ns/1ps
`default_nettype none
module vpc_checker #(
  parameter int HOLD_CYCLES = 30
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  input wire logic       clean_trigger,
  input wire logic       energise_cmd,
  input wire logic       target_present,
  input wire logic       band_energised,
  input wire logic       solenoid_output,
  input wire logic       valve_state,
  input wire logic       status_error,
  input wire logic       clean_done,
  input wire logic       fb_energised,
  input wire logic [4:0] features_enabled
);
  // ----------------------------------------
  // helper: high cycles of clean_done
  // ----------------------------------------
  int dcnt;
  always @(posedge clock) begin
    if (!reset_n || !clean_done) begin
      dcnt <= 0;
    end else begin
      dcnt <= dcnt + 1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  wait_ans_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("bus request not answered next cycle");
  wait_one_a: assert property (!waitrequest |=> waitrequest)
    else $error("waitrequest low too long");
  sol_release_a: assert property ($rose(band_energised) && solenoid_output && !energise_cmd
    |-> ##[1:5] !solenoid_output) else $error("solenoid held past target");
  sol_cause_a: assert property ($rose(solenoid_output) && !energise_cmd |-> $past(clean_trigger, 4))
    else $error("solenoid rose without trigger");
  sol_quiet_a: assert property (clean_done && !energise_cmd |-> !solenoid_output)
    else $error("clean started during hold");
  done_len_a: assert property ($fell(clean_done) |-> dcnt == HOLD_CYCLES)
    else $error("done pulse length wrong");
  done_min_a: assert property ($rose(clean_done) |-> clean_done [*8])
    else $error("done pulse too short");
  fb_copy_a: assert property (band_energised [*4] |-> fb_energised)
    else $error("energised feedback missing");
  flex_vs_a: assert property ((features_enabled == 5'h00) [*3] |-> !valve_state)
    else $error("valve state used in retrofit setup");
  rb_err_a: assert property ((features_enabled == 5'h1f) [*3] |-> !status_error)
    else $error("status error used in rule setup");
  feat_set_a: assert property (features_enabled == 5'h00 || features_enabled == 5'h1f)
    else $error("features partly enabled");
  fault_vs_a: assert property (!target_present && features_enabled == 5'h1f |-> ##[1:8] !valve_state)
    else $error("valve state high with target lost");
  c_done: cover property ($rose(clean_done));
  c_rel: cover property ($fell(solenoid_output));
  c_fault: cover property (!valve_state && features_enabled == 5'h1f);
endmodule
bind vpc_ctrl vpc_checker #(
  .HOLD_CYCLES(HOLD_CYCLES)
) chk_u (
  .clock(clock), .reset_n(reset_n), .read(read), .write(write), .waitrequest(waitrequest),
  .clean_trigger(clean_trigger), .energise_cmd(energise_cmd), .target_present(target_present),
  .band_energised(band_energised), .solenoid_output(solenoid_output), .valve_state(valve_state),
  .status_error(status_error), .clean_done(clean_done), .fb_energised(fb_energised),
  .features_enabled(features_enabled)
);
`default_nettype wire

// ===== test/vpc_ctrl_tb.sv
// Purpose: self-checking bench for the pulse clean controller
// Assumes: shortened counts, valve stroke of 6 cycles
// Notes:   irq expectation kept in exp_stat, cleared after each check
`timescale 1ns/1ps
`default_nettype none
module vpc_ctrl_tb;
  localparam int HOLD = 30;
  logic        clock, reset_n, read, write, waitrequest, clean_trigger, energise_cmd;
  logic        target_present, lose_target, band_deenergised, band_energised, solenoid_output;
  logic        valve_state, status_error, fb_energised, fb_deenergised, clean_done, irq;
  logic        led_green, led_white, led_blue, led_yellow, led_red, sol_q, lift_b, push_b;
  logic [7:0]  address;
  logic [31:0] writedata, readdata, rdata;
  logic [3:0]  byteenable;
  logic [4:0]  features_enabled;
  logic [7:0]  bad_ctrl [4] = '{8'h07, 8'h04, 8'h0a, 8'h02};
  int          num_errors = 0, checks = 0, n_sol = 0, dcnt = 0, exp_stat = 0, mask = 7, n;
  vpc_ctrl #(.TRIG_CYCLES(20), .HOLD_CYCLES(HOLD), .FLASH_CYCLES(4), .POS_CYCLES(50)) dut_u (
    .clock(clock), .reset_n(reset_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
    .clean_trigger(clean_trigger), .energise_cmd(energise_cmd), .target_present(target_present),
    .band_deenergised(band_deenergised), .band_energised(band_energised), .band_upper_lift(lift_b),
    .band_lower_push(push_b), .solenoid_output(solenoid_output), .valve_state(valve_state),
    .status_error(status_error), .fb_energised(fb_energised), .fb_deenergised(fb_deenergised),
    .clean_done(clean_done), .features_enabled(features_enabled), .led_green(led_green),
    .led_white(led_white), .led_blue(led_blue), .led_yellow(led_yellow), .led_red(led_red), .irq(irq));
  vpc_valve_model #(.MOVE(6)) valve_u (.clock(clock), .solenoid_output(solenoid_output),
    .lose_target(lose_target), .target_present(target_present),
    .band_deenergised(band_deenergised), .band_energised(band_energised));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
    n = 0;
    address <= a;
    writedata <= d;
    byteenable <= be;
    read <= !wr_en;
    write <= wr_en;
    do begin
      @(posedge clock);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) num_errors++;
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'hf);
    chk(rdata, e);
  endtask
  // bench holds the trigger up for len cycles
  task automatic trig(input int len);
    clean_trigger <= 1'b1;
    repeat (len) @(posedge clock);
    clean_trigger <= 1'b0;
  endtask
  task automatic wait_done();
    n = 0;
    while (clean_done !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    chk(n < 400, 1'b1);
  endtask
  task automatic irqc();
    chk(irq, (exp_stat & mask) != 0);
    rd(8'h08, exp_stat);
    bus(1'b1, 8'h08, exp_stat, 4'hf);
    exp_stat = 0;
    repeat (2) @(posedge clock);
    chk(irq, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d num_errors=%0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // clock, monitors, watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) begin
    sol_q <= solenoid_output;
    if (solenoid_output && !sol_q) n_sol++;
    if (clean_done === 1'b1) begin
      dcnt++;
    end else if (dcnt != 0) begin
      chk(dcnt, HOLD);
      dcnt = 0;
    end
  end
  initial begin
    #100000;
    num_errors++;
    tally_and_finish();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(34233));
    {reset_n, read, write, clean_trigger, energise_cmd, lose_target, lift_b, push_b} = '0;
    address = 8'h00;
    writedata = 32'h0;
    byteenable = 4'hf;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    rd(8'h00, 32'h10);
    rd(8'h0c, 32'h0);
    rd(8'h40, 32'h0);
    chk(features_enabled, 5'h1f);
    bus(1'b1, 8'h0c, 32'h7, 4'hf);
    bus(1'b1, 8'h00, 32'h06, 4'hf);
    bus(1'b1, 8'h00, 32'h1f, 4'he);
    rd(8'h00, 32'h06);
    repeat (5) @(posedge clock);
    chk({valve_state, status_error, fb_deenergised, fb_energised}, 4'b1010);
    chk({led_green, led_white, led_red}, 3'b100);
    rd(8'h04, 32'h3001);
    lift_b <= 1'b1;
    repeat (5) @(posedge clock);
    chk({led_green, led_blue, led_yellow}, 3'b110);
    lift_b <= 1'b0;
    push_b <= 1'b1;
    repeat (5) @(posedge clock);
    chk({led_green, led_blue, led_yellow}, 3'b101);
    push_b <= 1'b0;
    trig(5 + $urandom % 10);
    repeat (10) @(posedge clock);
    chk(n_sol, 0);
    trig(21 + $urandom % 8);
    wait_done();
    @(posedge clock);
    chk(led_white, 1'b1);
    trig(23);
    repeat (40) @(posedge clock);
    chk(n_sol, 1);
    exp_stat = 1;
    irqc();
    trig(25);
    wait_done();
    chk(n_sol, 2);
    repeat (HOLD + 5) @(posedge clock);
    exp_stat = 1;
    irqc();
    foreach (bad_ctrl[i]) begin
      bus(1'b1, 8'h00, bad_ctrl[i], 4'hf);
      trig(25);
      repeat (4) @(posedge clock);
      chk(n_sol, 2);
      chk(features_enabled, bad_ctrl[i][0] ? 5'h00 : 5'h1f);
      chk(valve_state, !bad_ctrl[i][0]);
      exp_stat = 4;
      irqc();
    end
    bus(1'b1, 8'h00, 32'h06, 4'hf);
    mask = 5;
    bus(1'b1, 8'h0c, mask, 4'hf);
    lose_target <= 1'b1;
    repeat (10) @(posedge clock);
    chk(valve_state, 1'b0);
    exp_stat = 2;
    irqc();
    lose_target <= 1'b0;
    tally_and_finish();
  end
endmodule
`default_nettype wire

// ===== test/vpc_valve_model.sv
// Purpose: valve and sensor behind the solenoid output
// Assumes: single seat valve, stroke of MOVE cycles each way
// Notes:   lost target blanks every band, as a real sensor would
`timescale 1ns/1ps
`default_nettype none
module vpc_valve_model #(
  parameter int MOVE = 6
) (
  input  wire logic clock,
  input  wire logic solenoid_output,
  input  wire logic lose_target,
  output var  logic target_present,
  output var  logic band_deenergised,
  output var  logic band_energised
);
  // ----------------------------------------
  // stroke
  // ----------------------------------------
  int pos = 0;
  always @(posedge clock) begin
    if (solenoid_output && pos < MOVE) begin
      pos <= pos + 1;
    end else if (!solenoid_output && pos > 0) begin
      pos <= pos - 1;
    end
  end
  always_comb target_present = !lose_target;
  always_comb band_deenergised = !lose_target && pos == 0;
  always_comb band_energised = !lose_target && pos == MOVE;
endmodule
`default_nettype wire
